/* hdl/dpsf_pkg.sv */
package dpsf_pkg;
  localparam int          DPSF_NUM_FLAGS  = 8;
  localparam int          DPSF_IDX_W      = 3;
  localparam int          DPSF_DATA_W     = 16;
  localparam int          DPSF_ADDR_W     = 12;
  localparam int          DPSF_REQ_BIT    = 0;
  localparam logic        DPSF_REQ_TAKE   = 1'b0;
  localparam logic        DPSF_REQ_FREE   = 1'b1;
  localparam int          DPSF_PULSE_CYC  = 2;
  localparam logic [1:0]  DPSF_CNT_ONE    = 2'h1;
  localparam logic [1:0]  DPSF_CNT_ZERO   = 2'h0;

  typedef enum logic [1:0] {
    DPSF_CMD_ACQUIRE,
    DPSF_CMD_RELEASE,
    DPSF_CMD_POLL,
    DPSF_CMD_INIT
  } dpsf_cmd_t;

  typedef enum {
    DPSF_ST_INIT_WR,
    DPSF_ST_IDLE,
    DPSF_ST_WRITE,
    DPSF_ST_GAP,
    DPSF_ST_READ,
    DPSF_ST_DONE
  } dpsf_state_t;
endpackage : dpsf_pkg

/* hdl/dpsf_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] after failed take, keep polling or withdraw
// [R2] device keeps one request latch per port
// [R3] first zero owner reads low here
// [R4] ownership stays until owner writes one
// [R5] pending request takes over on release
// [R6] new owner stays low until it releases
// [R7] simultaneous requests give exactly one winner
// [R8] earlier requester wins the token
// [R9] exact ties resolve arbitrarily
// [R10] host initialises flags after power-up
// [R11] write one to every flag at init
// [R12] acquire by writing zero then reading back
// [R13] losing side reads back a one
// [R14] release by writing one when finished
// [R15] eight flags operate independently
// [R16] only three low address lines select flag
// [R17] only data bit zero is written
// [R18] read value replicated on all data bits
// [R19] read latched while select and enable held
// [R20] device ties resolved atomically per cycle
module dpsf_host
  import dpsf_pkg::*;
#(
  parameter int DATA_W = DPSF_DATA_W,
  parameter int ADDR_W = DPSF_ADDR_W
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic              cmd_valid,
  input  wire logic [1:0]        cmd_op,
  input  wire logic [DPSF_IDX_W-1:0] cmd_flag,
  output var  logic              cmd_ready,
  output var  logic              rsp_valid,
  output var  logic              rsp_won,
  output var  logic              init_done,
  output var  logic              flag_space_select_n,
  output var  logic              write_n,
  output var  logic              out_enable_n,
  output var  logic [ADDR_W-1:0] flag_index_lines,
  output var  logic [DATA_W-1:0] data_out,
  output var  logic              data_oe,
  input  wire logic [DATA_W-1:0] data_in
);
  dpsf_state_t             st_q, st_d;
  logic [DPSF_IDX_W-1:0]   idx_q, idx_d;
  logic [1:0]              cnt_q, cnt_d;
  logic                    rd_q, rd_d;
  logic                    ready_q, ready_d;
  logic                    rv_q, rv_d;
  logic                    won_q, won_d;
  logic                    done_q, done_d;
  logic                    sel_n_q, sel_n_d;
  logic                    wr_n_q, wr_n_d;
  logic                    oe_n_q, oe_n_d;
  logic                    val_q, val_d;
  logic                    doe_q, doe_d;
  // strobes stay low PULSE cycles; the count reaching PULSE is the closing edge
  localparam logic [1:0]   PULSE = 2'(DPSF_PULSE_CYC);

  // flag value is the whole replicated word; any low bit counts as low
  function automatic logic flag_low(input logic [DATA_W-1:0] w);
    flag_low = ~(&w); // [R18]
  endfunction : flag_low

  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    cnt_d   = cnt_q;
    rd_d    = rd_q;
    ready_d = 1'b0;
    rv_d    = 1'b0;
    won_d   = won_q;
    done_d  = done_q;
    sel_n_d = 1'b1;
    wr_n_d  = 1'b1;
    oe_n_d  = 1'b1;
    val_d   = val_q;
    doe_d   = 1'b0;
    case (st_q)
      DPSF_ST_INIT_WR: begin
        // no power-up reset inside the device, so free every latch first
        sel_n_d = 1'b0; // [R10]
        wr_n_d  = 1'b0;
        doe_d   = 1'b1;
        val_d   = DPSF_REQ_FREE; // [R11]
        if (cnt_q == PULSE) begin
          cnt_d   = DPSF_CNT_ZERO;
          sel_n_d = 1'b1;
          wr_n_d  = 1'b1;
          doe_d   = 1'b0;
          if (idx_q == DPSF_IDX_W'(DPSF_NUM_FLAGS - 1)) begin
            st_d    = DPSF_ST_IDLE;
            idx_d   = '0;
            done_d  = 1'b1;
            ready_d = 1'b1;
          end else begin
            idx_d = idx_q + DPSF_IDX_W'(1); // [R15]
            st_d  = DPSF_ST_GAP;
            rd_d  = 1'b0;
          end
        end else begin
          cnt_d = cnt_q + DPSF_CNT_ONE;
        end
      end
      DPSF_ST_IDLE: begin
        ready_d = 1'b1;
        if (cmd_valid && ready_q) begin
          ready_d = 1'b0;
          idx_d   = cmd_flag;
          cnt_d   = DPSF_CNT_ZERO;
          case (dpsf_cmd_t'(cmd_op))
            DPSF_CMD_ACQUIRE: begin
              st_d  = DPSF_ST_WRITE;
              val_d = DPSF_REQ_TAKE; // [R12]
              rd_d  = 1'b1;
            end
            DPSF_CMD_RELEASE: begin
              // withdrawing a pending request is the same write as a release
              st_d  = DPSF_ST_WRITE;
              val_d = DPSF_REQ_FREE; // [R14] [R1]
              rd_d  = 1'b0;
            end
            DPSF_CMD_POLL: begin
              st_d = DPSF_ST_READ; // [R1]
            end
            DPSF_CMD_INIT: begin
              st_d   = DPSF_ST_INIT_WR;
              idx_d  = '0;
              done_d = 1'b0;
            end
            default: st_d = DPSF_ST_IDLE;
          endcase
        end
      end
      DPSF_ST_WRITE: begin
        sel_n_d = 1'b0;
        wr_n_d  = 1'b0;
        doe_d   = 1'b1;
        if (cnt_q == PULSE) begin
          cnt_d   = DPSF_CNT_ZERO;
          sel_n_d = 1'b1;
          wr_n_d  = 1'b1;
          doe_d   = 1'b0;
          // select rises after this closing cycle, giving the one-cycle gap a read needs
          if (rd_q) begin
            st_d = DPSF_ST_READ; // [R12] [R19]
          end else begin
            st_d = DPSF_ST_GAP;
          end
        end else begin
          cnt_d = cnt_q + DPSF_CNT_ONE;
        end
      end
      DPSF_ST_GAP: begin
        // one idle cycle between init writes, and before a release answers
        if (!done_q) begin
          st_d = DPSF_ST_INIT_WR; // [R19]
        end else begin
          st_d = DPSF_ST_DONE;
          won_d = 1'b0;
        end
      end
      DPSF_ST_READ: begin
        sel_n_d = 1'b0;
        oe_n_d  = 1'b0;
        if (cnt_q == PULSE) begin
          cnt_d   = DPSF_CNT_ZERO;
          won_d   = flag_low(data_in); // [R3] [R13]
          sel_n_d = 1'b1;
          oe_n_d  = 1'b1;
          st_d    = DPSF_ST_DONE;
        end else begin
          cnt_d = cnt_q + DPSF_CNT_ONE;
        end
      end
      DPSF_ST_DONE: begin
        rv_d    = 1'b1;
        ready_d = 1'b1;
        st_d    = DPSF_ST_IDLE;
      end
      default: st_d = DPSF_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q    <= DPSF_ST_INIT_WR;
      idx_q   <= '0;
      cnt_q   <= DPSF_CNT_ZERO;
      rd_q    <= 1'b0;
      ready_q <= 1'b0;
      rv_q    <= 1'b0;
      won_q   <= 1'b0;
      done_q  <= 1'b0;
      sel_n_q <= 1'b1;
      wr_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      val_q   <= DPSF_REQ_FREE;
      doe_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      idx_q   <= idx_d;
      cnt_q   <= cnt_d;
      rd_q    <= rd_d;
      ready_q <= ready_d;
      rv_q    <= rv_d;
      won_q   <= won_d;
      done_q  <= done_d;
      sel_n_q <= sel_n_d;
      wr_n_q  <= wr_n_d;
      oe_n_q  <= oe_n_d;
      val_q   <= val_d;
      doe_q   <= doe_d;
    end
  end

  assign cmd_ready           = ready_q;
  assign rsp_valid           = rv_q;
  assign rsp_won             = won_q;
  assign init_done           = done_q;
  assign flag_space_select_n = sel_n_q;
  assign write_n             = wr_n_q;
  assign out_enable_n        = oe_n_q;
  // upper address lines are don't-care for the flags; held at zero
  assign flag_index_lines    = ADDR_W'(idx_q); // [R16]
  // only bit zero matters to the device; copy it everywhere for tidiness
  assign data_out            = {DATA_W{val_q}}; // [R17]
  assign data_oe             = doe_q;
endmodule : dpsf_host
`default_nettype wire

/* verif/dpsf_host_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module dpsf_host_chk
  import dpsf_pkg::*;
#(parameter int DATA_W = DPSF_DATA_W, parameter int ADDR_W = DPSF_ADDR_W) (
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic              cmd_valid,
  input wire logic [1:0]        cmd_op,
  input wire logic              cmd_ready,
  input wire logic              rsp_valid,
  input wire logic              rsp_won,
  input wire logic              init_done,
  input wire logic              flag_space_select_n,
  input wire logic              write_n,
  input wire logic              out_enable_n,
  input wire logic [ADDR_W-1:0] flag_index_lines,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe,
  input wire logic [DATA_W-1:0] data_in
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire take = cmd_valid && cmd_ready;
  a_acq_answer: assert property (take && cmd_op == 2'h0 |-> ##8 rsp_valid) else $error("acquire late");
  a_rel_answer: assert property (take && cmd_op == 2'h1 |-> ##6 rsp_valid) else $error("release late");
  a_poll_answer: assert property (take && cmd_op == 2'h2 |-> ##5 rsp_valid) else $error("poll late");
  a_won_from_bus: assert property ($rose(out_enable_n) |-> rsp_won == ($past(data_in) != '1))
    else $error("won");
  a_strobe_width: assert property ($fell(write_n) |=> !write_n ##1 write_n) else $error("strobe width");
  a_no_rd_wr: assert property (write_n || out_enable_n) else $error("read during write");
  a_index_high: assert property (!write_n |-> flag_index_lines[ADDR_W-1:3] == '0) else $error("address");
  a_init_ones: assert property (!write_n && !init_done |-> data_out == '1) else $error("init data");
  a_data_repl: assert property (!write_n |-> data_out == '0 || data_out == '1) else $error("data bits");
  a_select_match: assert property (flag_space_select_n == (write_n && out_enable_n)) else $error("select");
  a_drive_window: assert property (data_oe == !write_n) else $error("data drive");
  c_init: cover property ($rose(init_done));
  c_won: cover property (rsp_valid && rsp_won);
  c_lost: cover property ($rose(out_enable_n) && !rsp_won);
endmodule : dpsf_host_chk
`default_nettype wire

/* verif/dpsf_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpsf_dev_model (
  input  wire logic        clock,
  input  wire logic        sel_n,
  input  wire logic        write_n,
  input  wire logic        oe_n,
  input  wire logic [11:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        b_we,
  input  wire logic [2:0]  b_idx,
  input  wire logic        b_val,
  output var  logic [15:0] rdata
);
  // stale power-up requests, nothing clears them but writes
  logic [7:0] req_a = 8'h5A, req_b = 8'h00, own_a = 8'h00, own_b = 8'h00;
  logic       rd_q = 1'b0;
  initial rdata = 16'hA5A5;
  always @(posedge clock) begin : upd
    logic [7:0] na, nb, oa, ob;
    na = req_a;
    nb = req_b;
    oa = own_a;
    ob = own_b;
    if (!sel_n && !write_n) na[addr[2:0]] = wdata[0];
    if (b_we) nb[b_idx] = b_val;
    for (int i = 0; i < 8; i++) begin
      if (oa[i] && na[i]) oa[i] = 1'b0;
      if (ob[i] && nb[i]) ob[i] = 1'b0;
      // port a wins exact ties, one owner only
      if (!oa[i] && !ob[i]) begin
        oa[i] = !na[i];
        ob[i] = na[i] && !nb[i];
      end
    end
    req_a <= na;
    req_b <= nb;
    own_a <= oa;
    own_b <= ob;
    // bus not read shows changing junk
    if (!sel_n && !oe_n) begin
      if (!rd_q) rdata <= {16{!oa[addr[2:0]]}};
    end else rdata <= ~rdata;
    rd_q <= !sel_n && !oe_n;
  end
endmodule : dpsf_dev_model
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dpsf_pkg::*;
  logic        clock = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, b_we = 1'b0, b_val = 1'b1;
  logic [1:0]  cmd_op = 2'h0;
  logic [2:0]  cmd_flag = 3'h0, b_idx = 3'h0;
  wire logic   cmd_ready, rsp_valid, rsp_won, init_done, sel_n, write_n, oe_n, data_oe;
  wire logic [11:0] addr;
  wire logic [15:0] dout, din;
  int fails = 0, comparisons = 0, cycles = 0;
  always #10 clock = ~clock;
  dpsf_host dpsf_host_inst (.clock(clock), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_flag(cmd_flag), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_won(rsp_won), .init_done(init_done),
    .flag_space_select_n(sel_n), .write_n(write_n), .out_enable_n(oe_n), .flag_index_lines(addr),
    .data_out(dout), .data_oe(data_oe), .data_in(din));
  dpsf_dev_model dpsf_dev_model_inst (.clock(clock), .sel_n(sel_n), .write_n(write_n), .oe_n(oe_n), .addr(addr),
    .wdata(dout), .b_we(b_we), .b_idx(b_idx), .b_val(b_val), .rdata(din));
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic cmd(input logic [1:0] op, input logic [2:0] f, input logic exp);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 60) begin
      @(posedge clock);
      #1 n++;
    end
    {cmd_valid, cmd_op, cmd_flag} = {1'b1, op, f};
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    n = 0;
    while ((op == 2'h3 ? cmd_ready : rsp_valid) !== 1'b1 && n < 60) begin
      @(posedge clock);
      #1 n++;
    end
    check("answer", 16'h0001, {15'h0, n < 60});
    if (op != 2'h3) check("rsp_won", {15'h0, exp}, {15'h0, rsp_won});
  endtask : cmd
  task automatic bwr(input logic [2:0] f, input logic v);
    @(posedge clock);
    #1 {b_we, b_idx, b_val} = {1'b1, f, v};
    @(posedge clock);
    #1 b_we = 1'b0;
  endtask : bwr
  task automatic t_init;
    for (int i = 0; i < 8; i++) bwr(i[2:0], 1'b1);
    cmd(DPSF_CMD_POLL, 3'h6, 1'b0);
    check("req_a", 16'h00FF, {8'h0, dpsf_dev_model_inst.req_a});
    cmd(DPSF_CMD_INIT, 3'h0, 1'b0);
    check("init_done", 16'h0001, {15'h0, init_done});
    $display("t_init done");
  endtask : t_init
  task automatic t_handover;
    cmd(DPSF_CMD_ACQUIRE, 3'h2, 1'b1);
    bwr(3'h2, 1'b0);
    cmd(DPSF_CMD_POLL, 3'h2, 1'b1);
    cmd(DPSF_CMD_RELEASE, 3'h2, 1'b0);
    check("own_b", 16'h0004, {8'h0, dpsf_dev_model_inst.own_b});
    cmd(DPSF_CMD_ACQUIRE, 3'h2, 1'b0);
    cmd(DPSF_CMD_POLL, 3'h2, 1'b0);
    bwr(3'h2, 1'b1);
    cmd(DPSF_CMD_POLL, 3'h2, 1'b1);
    cmd(DPSF_CMD_RELEASE, 3'h2, 1'b0);
    $display("t_handover done");
  endtask : t_handover
  task automatic t_indep;
    bwr(3'h5, 1'b0);
    for (int f = 0; f < 8; f++) cmd(DPSF_CMD_ACQUIRE, f[2:0], f != 5);
    for (int f = 0; f < 8; f++) cmd(DPSF_CMD_RELEASE, f[2:0], 1'b0);
    check("own_b", 16'h0020, {8'h0, dpsf_dev_model_inst.own_b});
    bwr(3'h5, 1'b1);
    $display("t_indep done");
  endtask : t_indep
  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    #1 reset_n = 1'b1;
    t_init();
    t_handover();
    t_indep();
    wrap_up();
  end
endmodule : testbench
bind dpsf_host dpsf_host_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) dpsf_host_chk_inst (.clock(clock), .reset_n(reset_n),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_won(rsp_won),
  .init_done(init_done), .flag_space_select_n(flag_space_select_n), .write_n(write_n), .out_enable_n(out_enable_n),
  .flag_index_lines(flag_index_lines), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
`default_nettype wire
